// file: hdl/tw_line_monitor.sv
// Synchronises both bus lines and tracks whether any master holds the bus.
module tw_line_monitor
	import tw_pkg::*;
(
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic scl_i,
	input  wire logic sda_i,
	output logic      scl_s,
	output logic      sda_s,
	output logic      bus_busy
);

	logic [1:0] meta_ff;
	logic [1:0] sync_ff;
	logic       sda_d_ff;
	logic       busy_ff;
	logic       nxt_busy;

	// A start seen on the wire marks the bus busy, a stop frees it.
	// Only the second synchroniser stage and its delayed data copy (sda_d_ff) feed this detector.
	always_comb begin
		nxt_busy = busy_ff;
		if (sync_ff[1] && sda_d_ff && !sync_ff[0]) begin
			nxt_busy = 1'b1;
		end else if (sync_ff[1] && !sda_d_ff && sync_ff[0]) begin
			nxt_busy = 1'b0;
		end
	end

	// Two flops per line; bit 1 is the clock line, bit 0 the data line.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_ff  <= 2'h3;
			sync_ff  <= 2'h3;
			sda_d_ff <= 1'b1;
			busy_ff  <= 1'b0;
		end else begin
			meta_ff  <= {scl_i, sda_i};
			sync_ff  <= meta_ff;
			sda_d_ff <= sync_ff[0];
			busy_ff  <= nxt_busy;
		end
	end

	assign scl_s    = sync_ff[1];
	assign sda_s    = sync_ff[0];
	assign bus_busy = busy_ff;

endmodule

// file: hdl/tw_master.sv
// Implementation choices: register access over APB and the register addresses.
module tw_master
	import tw_pkg::*;
#(
	parameter int QUARTER = QUARTER_CYCLES
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              scl_i,
	output logic                   scl_o,
	output logic                   scl_oe,
	input  wire logic              sda_i,
	output logic                   sda_o,
	output logic                   sda_oe,
	output logic                   irq
);

	localparam logic [7:0] QLAST = 8'(QUARTER - 1);

	logic       scl_s;
	logic       sda_s;
	logic       bus_busy;

	// Engine state.
	tw_state_t  state_ff,   nxt_state;
	logic [1:0] phase_ff,   nxt_phase;
	logic [7:0] qcnt_ff,    nxt_qcnt;
	logic [3:0] bit_ff,     nxt_bit;
	logic [7:0] shreg_ff,   nxt_shreg;
	logic       rx_ff,      nxt_rx;
	logic       addr_ff,    nxt_addr;
	logic       addr_rw_ff, nxt_addr_rw;
	logic       mode_rx_ff, nxt_mode_rx;
	logic       started_ff, nxt_started;
	logic       ack_ff,     nxt_ack;
	logic       scl_oe_ff,  nxt_scl_oe;
	logic       sda_oe_ff,  nxt_sda_oe;

	// Register state.
	logic        flag_ff,   nxt_flag;
	logic        acken_ff,  nxt_acken;
	logic        sta_ff,    nxt_sta;
	logic        sto_ff,    nxt_sto;
	logic        wcol_ff,   nxt_wcol;
	logic        en_ff,     nxt_en;
	logic        ien_ff,    nxt_ien;
	logic [7:0]  status_ff, nxt_status;
	logic [7:0]  data_ff,   nxt_data;
	logic [31:0] prdata_ff, nxt_prdata;
	logic        irq_ff,    nxt_irq;

	// Engine events handed to the register group.
	logic       ev_done;
	logic       ev_rxload;
	logic       ev_stop_end;
	logic [7:0] ev_status;

	logic       tick;
	logic       own_bit;
	logic       bit_one;
	logic       arb_lost;
	logic       byte_end;
	logic       start_end;
	logic [7:0] code;
	logic       setup;
	logic       wr_ctrl;
	logic       wr_data;
	logic       mapped;

	tw_line_monitor u_mon (
		.pclk     (pclk),
		.presetn  (presetn),
		.scl_i    (scl_i),
		.sda_i    (sda_i),
		.scl_s    (scl_s),
		.sda_s    (sda_s),
		.bus_busy (bus_busy)
	);

	// A quarter ends after QUARTER cycles, but the high phase is held open
	// while a slave stretches the clock line low.
	assign tick = (qcnt_ff == QLAST) && !(phase_ff == PH_SCL_UP && !scl_s);

	// The bit we drive: data bits on transmit, the ack slot on receive.
	assign own_bit  = rx_ff ? (bit_ff == BIT_ACK) : (bit_ff != BIT_ACK);
	assign bit_one  = rx_ff ? ((bit_ff != BIT_ACK) || !acken_ff)
	                        : ((bit_ff == BIT_ACK) || shreg_ff[7]);
	assign arb_lost = en_ff && state_ff == S_BYTE && tick &&
	                  phase_ff == PH_SCL_UP && own_bit && bit_one && !sda_s;
	assign byte_end = en_ff && state_ff == S_BYTE && tick &&
	                  phase_ff == PH_LAST && bit_ff == BIT_ACK;
	assign start_end = en_ff && state_ff == S_START && tick &&
	                   phase_ff == PH_LAST;
	assign code = status_ff & STAT_CODE_MASK;

	// Engine: start, byte, stop and hold sequencing.
	always_comb begin
		nxt_state   = state_ff;
		nxt_phase   = phase_ff;
		nxt_qcnt    = 8'h00;
		nxt_bit     = bit_ff;
		nxt_shreg   = shreg_ff;
		nxt_rx      = rx_ff;
		nxt_addr    = addr_ff;
		nxt_addr_rw = addr_rw_ff;
		nxt_mode_rx = mode_rx_ff;
		nxt_started = started_ff;
		nxt_ack     = ack_ff;
		ev_done     = 1'b0;
		ev_rxload   = 1'b0;
		ev_stop_end = 1'b0;
		ev_status   = status_ff;
		if (state_ff == S_START || state_ff == S_BYTE ||
		    state_ff == S_STOP) begin
			if (tick) begin
				nxt_phase = phase_ff + 2'h1;
			end else if (qcnt_ff != QLAST) begin
				nxt_qcnt = qcnt_ff + 8'h01;
			end else begin
				nxt_qcnt = qcnt_ff;
			end
		end
		if (!en_ff) begin
			nxt_state   = S_IDLE;
			nxt_started = 1'b0;
		end else begin
			case (state_ff)
				S_IDLE: begin
					if (sta_ff && !flag_ff) begin
						nxt_state = S_WAIT_FREE;
					end
				end
				S_WAIT_FREE: begin
					if (!bus_busy) begin
						nxt_state = S_START;
						nxt_phase = PH_FIRST;
					end
				end
				S_START: begin
					if (start_end) begin
						ev_done     = 1'b1;
						ev_status   = started_ff ? SC_RESTART : SC_START;
						nxt_started = 1'b1;
						nxt_state   = S_HOLD;
					end
				end
				S_BYTE: begin
					if (arb_lost) begin
						ev_done     = 1'b1;
						ev_status   = SC_LOST;
						nxt_started = 1'b0;
						nxt_state   = S_LOST;
					end else if (tick && phase_ff == PH_SCL_UP) begin
						if (bit_ff == BIT_ACK) begin
							nxt_ack = !sda_s;
						end else begin
							nxt_shreg = {shreg_ff[6:0], sda_s};
						end
					end else if (tick && phase_ff == PH_LAST) begin
						if (bit_ff != BIT_ACK) begin
							nxt_bit = bit_ff + 4'h1;
						end else begin
							ev_done   = 1'b1;
							nxt_state = S_HOLD;
							if (addr_ff) begin
								nxt_mode_rx = addr_rw_ff;
								if (addr_rw_ff) begin
									ev_status = ack_ff ? SC_RADDR_ACK
									                   : SC_RADDR_NACK;
								end else begin
									ev_status = ack_ff ? SC_WADDR_ACK
									                   : SC_WADDR_NACK;
								end
							end else if (rx_ff) begin
								ev_rxload = 1'b1;
								ev_status = acken_ff ? SC_RX_ACK : SC_RX_NACK;
							end else begin
								ev_status = ack_ff ? SC_TX_ACK : SC_TX_NACK;
							end
						end
					end
				end
				S_HOLD: begin
					// Bus activity stays paused while the flag is up.
					if (!flag_ff) begin
						nxt_phase = PH_FIRST;
						nxt_bit   = 4'h0;
						if (sto_ff) begin
							nxt_state = S_STOP;
						end else if (sta_ff) begin
							nxt_state = S_START;
						end else if (code == SC_START || code == SC_RESTART) begin
							nxt_state   = S_BYTE;
							nxt_addr    = 1'b1;
							nxt_rx      = 1'b0;
							nxt_shreg   = data_ff;
							nxt_addr_rw = data_ff[0];
						end else if (code == SC_WADDR_ACK ||
						             code == SC_WADDR_NACK ||
						             code == SC_TX_ACK ||
						             code == SC_TX_NACK) begin
							nxt_state = S_BYTE;
							nxt_addr  = 1'b0;
							nxt_rx    = 1'b0;
							nxt_shreg = data_ff;
						end else if (code == SC_RADDR_ACK ||
						             code == SC_RX_ACK) begin
							nxt_state = S_BYTE;
							nxt_addr  = 1'b0;
							nxt_rx    = 1'b1;
						end
						// Other codes (0x48, 0x58) wait for a condition.
					end
				end
				S_STOP: begin
					if (tick && phase_ff == PH_LAST) begin
						ev_stop_end = 1'b1;
						nxt_started = 1'b0;
						nxt_state   = sta_ff ? S_WAIT_FREE : S_IDLE;
					end
				end
				S_LOST: begin
					// Lines are released; unaddressed until told otherwise.
					if (!flag_ff) begin
						nxt_state = sta_ff ? S_WAIT_FREE : S_IDLE;
					end
				end
				default: begin
					nxt_state = S_IDLE;
				end
			endcase
		end
		// Wanted line levels, registered one cycle later; the lag is
		// harmless since all timing is counted in whole quarters.
		nxt_scl_oe = 1'b0;
		nxt_sda_oe = 1'b0;
		case (state_ff)
			S_START: begin
				nxt_scl_oe = started_ff && (phase_ff < PH_SCL_UP);
				nxt_sda_oe = (phase_ff == PH_LAST);
			end
			S_BYTE: begin
				// The shift register moves on while the clock is still
				// high, so the line keeps its bit until the clock is low.
				nxt_scl_oe = (phase_ff < PH_SCL_UP);
				if (phase_ff == PH_FIRST || phase_ff == PH_LAST) begin
					nxt_sda_oe = sda_oe_ff;
				end else begin
					nxt_sda_oe = !bit_one;
				end
			end
			S_STOP: begin
				nxt_scl_oe = (phase_ff < PH_SCL_UP);
				nxt_sda_oe = (phase_ff != PH_LAST);
			end
			S_HOLD: begin
				nxt_scl_oe = 1'b1;
				nxt_sda_oe = sda_oe_ff;
			end
			default: begin
				nxt_scl_oe = 1'b0;
				nxt_sda_oe = 1'b0;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff   <= S_IDLE;
			phase_ff   <= PH_FIRST;
			qcnt_ff    <= 8'h00;
			bit_ff     <= 4'h0;
			shreg_ff   <= 8'h00;
			rx_ff      <= 1'b0;
			addr_ff    <= 1'b0;
			addr_rw_ff <= 1'b0;
			mode_rx_ff <= 1'b0;
			started_ff <= 1'b0;
			ack_ff     <= 1'b0;
			scl_oe_ff  <= 1'b0;
			sda_oe_ff  <= 1'b0;
		end else begin
			state_ff   <= nxt_state;
			phase_ff   <= nxt_phase;
			qcnt_ff    <= nxt_qcnt;
			bit_ff     <= nxt_bit;
			shreg_ff   <= nxt_shreg;
			rx_ff      <= nxt_rx;
			addr_ff    <= nxt_addr;
			addr_rw_ff <= nxt_addr_rw;
			mode_rx_ff <= nxt_mode_rx;
			started_ff <= nxt_started;
			ack_ff     <= nxt_ack;
			scl_oe_ff  <= nxt_scl_oe;
			sda_oe_ff  <= nxt_sda_oe;
		end
	end

	// APB decode. Zero wait states: read data is latched in the setup
	// cycle, so prdata comes straight from a flop in the access cycle.
	assign setup   = psel && !penable;
	assign wr_ctrl = psel && penable && pwrite && paddr == ADDR_CTRL;
	assign wr_data = psel && penable && pwrite && paddr == ADDR_DATA;
	assign mapped  = paddr == ADDR_CTRL || paddr == ADDR_STAT ||
	                 paddr == ADDR_DATA;

	// Register group; hardware events win over software writes.
	always_comb begin
		nxt_flag   = flag_ff;
		nxt_acken  = acken_ff;
		nxt_sta    = sta_ff;
		nxt_sto    = sto_ff;
		nxt_wcol   = wcol_ff;
		nxt_en     = en_ff;
		nxt_ien    = ien_ff;
		nxt_status = ev_done ? ev_status : status_ff;
		nxt_data   = data_ff;
		nxt_prdata = prdata_ff;
		if (wr_ctrl) begin
			nxt_acken = pwdata[B_ACKEN];
			nxt_sta   = pwdata[B_STA];
			nxt_sto   = pwdata[B_STO];
			nxt_en    = pwdata[B_EN];
			nxt_ien   = pwdata[B_IEN];
			if (pwdata[B_FLAG]) begin
				nxt_flag = 1'b0;
			end
		end
		if (ev_done) begin
			nxt_flag = 1'b1;
		end
		if (ev_stop_end) begin
			nxt_sto = 1'b0;
		end
		if (wr_data) begin
			if (flag_ff) begin
				nxt_data = pwdata[7:0];
				nxt_wcol = 1'b0;
			end else begin
				nxt_wcol = 1'b1;
			end
		end
		if (ev_rxload) begin
			nxt_data = shreg_ff;
		end
		if (setup) begin
			if (paddr == ADDR_CTRL) begin
				nxt_prdata = {24'h000000, flag_ff, acken_ff, sta_ff, sto_ff,
				              wcol_ff, en_ff, 1'b0, ien_ff};
			end else if (paddr == ADDR_STAT) begin
				nxt_prdata = {24'h000000, code};
			end else if (paddr == ADDR_DATA) begin
				nxt_prdata = {24'h000000, data_ff};
			end else begin
				nxt_prdata = 32'h00000000;
			end
		end
		nxt_irq = flag_ff && ien_ff;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag_ff   <= 1'b0;
			acken_ff  <= 1'b0;
			sta_ff    <= 1'b0;
			sto_ff    <= 1'b0;
			wcol_ff   <= 1'b0;
			en_ff     <= 1'b0;
			ien_ff    <= 1'b0;
			status_ff <= SC_NONE;
			data_ff   <= DATA_RESET;
			prdata_ff <= 32'h00000000;
			irq_ff    <= 1'b0;
		end else begin
			flag_ff   <= nxt_flag;
			acken_ff  <= nxt_acken;
			sta_ff    <= nxt_sta;
			sto_ff    <= nxt_sto;
			wcol_ff   <= nxt_wcol;
			en_ff     <= nxt_en;
			ien_ff    <= nxt_ien;
			status_ff <= nxt_status;
			data_ff   <= nxt_data;
			prdata_ff <= nxt_prdata;
			irq_ff    <= nxt_irq;
		end
	end

	// Open-drain lines: only ever pull low.
	assign scl_o   = 1'b0;
	assign sda_o   = 1'b0;
	assign scl_oe  = scl_oe_ff;
	assign sda_oe  = sda_oe_ff;
	assign prdata  = prdata_ff;
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign irq     = irq_ff;

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_wait_free: assert property (
		(state_ff == S_WAIT_FREE && bus_busy && en_ff) |=>
		state_ff == S_WAIT_FREE) else $error("start while bus busy");
	a_start_code: assert property (
		(start_end && !started_ff) |=> flag_ff && status_ff == SC_START)
		else $error("start completion not reported as 0x08");
	a_restart_code: assert property (
		(start_end && started_ff) |=> status_ff == SC_RESTART && started_ff)
		else $error("repeated start not reported as 0x10");
	a_flag_clear: assert property (
		(wr_ctrl && pwdata[B_FLAG] && !ev_done) |=> !flag_ff)
		else $error("flag not cleared by writing one");
	a_read_addr: assert property (
		(byte_end && addr_ff && addr_rw_ff) |=> mode_rx_ff && flag_ff &&
		(status_ff == SC_RADDR_ACK || status_ff == SC_RADDR_NACK))
		else $error("read address result wrong");
	a_rx_data: assert property (
		(byte_end && rx_ff) |=> flag_ff && data_ff == $past(shreg_ff))
		else $error("received byte not in data register");
	a_tx_next: assert property (
		(state_ff == S_HOLD && !flag_ff && !sta_ff && !sto_ff && en_ff &&
		(code == SC_TX_ACK || code == SC_TX_NACK)) |=>
		state_ff == S_BYTE && !rx_ff) else $error("next byte not sent");
	a_arb_lost: assert property (
		arb_lost |=> state_ff == S_LOST && status_ff == SC_LOST &&
		!scl_oe_ff ##1 !sda_oe_ff) else $error("arbitration loss wrong");
	a_lost_start: assert property (
		(state_ff == S_LOST && !flag_ff && sta_ff && en_ff) |=>
		state_ff == S_WAIT_FREE) else $error("no restart after loss");
	a_stop_clear: assert property (
		(state_ff == S_STOP && tick && phase_ff == PH_LAST && en_ff) |=>
		!sto_ff) else $error("stop request not self-cleared");
	a_wr_collide: assert property (
		(wr_data && !flag_ff && !ev_rxload) |=> wcol_ff && $stable(data_ff))
		else $error("collision write not discarded");
	a_nack_hold: assert property (
		(state_ff == S_HOLD && code == SC_RX_NACK && !sta_ff && !sto_ff &&
		en_ff) |=> state_ff == S_HOLD) else $error("byte after 0x58");
	a_irq_pause: assert property (
		(flag_ff && ien_ff && state_ff == S_HOLD) |=> irq &&
		state_ff == S_HOLD) else $error("no pause or interrupt");

endmodule

// file: inc/tw_pkg.sv
package tw_pkg;

	// Register byte addresses on the APB port.
	localparam int          ADDR_W    = 8;
	localparam logic [7:0]  ADDR_CTRL = 8'h00;
	localparam logic [7:0]  ADDR_STAT = 8'h04;
	localparam logic [7:0]  ADDR_DATA = 8'h08;

	// Control register bit positions.
	localparam int B_FLAG  = 7;
	localparam int B_ACKEN = 6;
	localparam int B_STA   = 5;
	localparam int B_STO   = 4;
	localparam int B_WCOL  = 3;
	localparam int B_EN    = 2;
	localparam int B_IEN   = 0;

	// Reset values.
	localparam logic [7:0] DATA_RESET = 8'hFF;
	localparam logic [7:0] SC_NONE    = 8'hF8;

	// Status codes with the prescaler bits at zero.
	localparam logic [7:0] SC_START      = 8'h08;
	localparam logic [7:0] SC_RESTART    = 8'h10;
	localparam logic [7:0] SC_WADDR_ACK  = 8'h18;
	localparam logic [7:0] SC_WADDR_NACK = 8'h20;
	localparam logic [7:0] SC_TX_ACK     = 8'h28;
	localparam logic [7:0] SC_TX_NACK    = 8'h30;
	localparam logic [7:0] SC_LOST       = 8'h38;
	localparam logic [7:0] SC_RADDR_ACK  = 8'h40;
	localparam logic [7:0] SC_RADDR_NACK = 8'h48;
	localparam logic [7:0] SC_RX_ACK     = 8'h50;
	localparam logic [7:0] SC_RX_NACK    = 8'h58;

	// Keeps the code bits and forces the prescaler bits to zero.
	localparam logic [7:0] STAT_CODE_MASK = 8'hF8;

	// Bit timing: four quarters make one serial clock period.
	localparam int CLK_PERIOD_NS  = 100;
	localparam int SCL_PERIOD_NS  = 800;
	localparam int QUARTER_RAW    = SCL_PERIOD_NS / 4 / CLK_PERIOD_NS;
	localparam int QUARTER_CYCLES = (QUARTER_RAW < 1) ? 1 : QUARTER_RAW;

	// Bit index of the acknowledge slot, and quarter phases.
	localparam logic [3:0] BIT_ACK   = 4'h8;
	localparam logic [1:0] PH_FIRST  = 2'h0;
	localparam logic [1:0] PH_SCL_UP = 2'h2;
	localparam logic [1:0] PH_LAST   = 2'h3;

	typedef enum logic [6:0] {
		S_IDLE      = 7'h01,
		S_WAIT_FREE = 7'h02,
		S_START     = 7'h04,
		S_BYTE      = 7'h08,
		S_HOLD      = 7'h10,
		S_STOP      = 7'h20,
		S_LOST      = 7'h40
	} tw_state_t;

endpackage

// file: testbench/testbench.sv
// Drives the master over APB against one slave model on a pulled-up bus.
module testbench
	import tw_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic              pclk;
	logic              presetn;
	logic              psel;
	logic              penable;
	logic              pwrite;
	logic [ADDR_W-1:0] paddr;
	logic [31:0]       pwdata;
	logic [31:0]       prdata;
	logic              pready;
	logic              pslverr;
	logic              scl_oe;
	logic              sda_oe;
	logic              s_oe;
	logic              jam;
	logic              irq;
	logic              scl_w;
	logic              sda_w;
	logic [31:0]       rd;
	logic              er;
	int                err_count;
	int                n_compared;
	int                cyc;

	// Open-drain wires: low if anyone pulls, else the pull-up wins.
	assign scl_w = !scl_oe;
	assign sda_w = !(sda_oe | s_oe | jam);

	tw_master #(.QUARTER(2)) DUT (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .scl_i(scl_w), .scl_o(),
		.scl_oe(scl_oe), .sda_i(sda_w), .sda_o(), .sda_oe(sda_oe),
		.irq(irq)
	);

	tw_slave_model SLV (.scl(scl_w), .sda(sda_w), .sda_oe(s_oe));

	// Free-running system clock.
	always #50 pclk = ~pclk;

	task end_sim;
		if (err_count == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// A hang counts as a failure; the run needs well under this many cycles.
	always @(posedge pclk) begin
		cyc = cyc + 1;
		if (cyc == 20000) begin
			err_count++;
			end_sim();
		end
	end

	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// One APB transfer; the request holds until pready is seen high.
	task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task rdc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp,
			input string nm);
		apb(1'b0, a, 8'h00);
		chk(nm, {24'h000000, exp & m}, rd & {24'hFFFFFF, m});
		chk("pslverr", 32'h0, {31'h0, er});
	endtask

	// Polls a control bit with a bounded number of reads.
	task wait_ctl(input int b, input logic v);
		int i;
		i = 0;
		do begin
			apb(1'b0, ADDR_CTRL, 8'h00);
			i++;
		end while (rd[b] !== v && i < 400);
		chk("ctrl bit wait", {31'h0, v}, {31'h0, rd[b]});
	endtask

	task step(input logic ld, input logic [7:0] d, input logic [7:0] c,
			input logic [7:0] st);
		if (ld)
			apb(1'b1, ADDR_DATA, d);
		apb(1'b1, ADDR_CTRL, c);
		wait_ctl(B_FLAG, 1'b1);
		rdc(ADDR_STAT, STAT_CODE_MASK, st, "status");
	endtask

	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		jam = 1'b0;
		err_count = 0;
		n_compared = 0;
		cyc = 0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		rdc(ADDR_CTRL, 8'hFF, 8'h00, "ctrl reset");
		rdc(ADDR_STAT, 8'hFF, SC_NONE, "status reset");
		rdc(ADDR_DATA, 8'hFF, DATA_RESET, "data reset");
		apb(1'b0, 8'h0C, 8'h00);
		chk("unmapped err", 32'h1, {31'h0, er});
		chk("unmapped data", 32'h0, rd);
		apb(1'b1, ADDR_DATA, 8'h54);
		rdc(ADDR_CTRL, 8'h08, 8'h08, "collision");
		rdc(ADDR_DATA, 8'hFF, DATA_RESET, "discarded");
		step(1'b0, 8'h00, 8'hA5, SC_START);
		chk("irq on", 32'h1, {31'h0, irq});
		step(1'b1, 8'h54, 8'h84, SC_WADDR_ACK);
		rdc(ADDR_CTRL, 8'h08, 8'h00, "collision clear");
		chk("irq masked", 32'h0, {31'h0, irq});
		step(1'b1, 8'h81, 8'h84, SC_TX_ACK);
		step(1'b1, 8'hC3, 8'h84, SC_TX_NACK);
		step(1'b1, 8'h12, 8'h84, SC_TX_ACK);
		step(1'b0, 8'h00, 8'hA4, SC_RESTART);
		step(1'b1, 8'h55, 8'hC4, SC_RADDR_ACK);
		step(1'b0, 8'h00, 8'hC4, SC_RX_ACK);
		rdc(ADDR_DATA, 8'hFF, 8'h96, "rx byte 1");
		step(1'b0, 8'h00, 8'h84, SC_RX_NACK);
		rdc(ADDR_DATA, 8'hFF, 8'hA7, "rx byte 2");
		step(1'b0, 8'h00, 8'hA4, SC_RESTART);
		step(1'b1, 8'h62, 8'h84, SC_WADDR_NACK);
		step(1'b0, 8'h00, 8'hB4, SC_START);
		rdc(ADDR_CTRL, 8'h10, 8'h00, "stop self clear");
		step(1'b1, 8'h63, 8'h84, SC_RADDR_NACK);
		apb(1'b1, ADDR_CTRL, 8'h94);
		wait_ctl(B_STO, 1'b0);
		rdc(ADDR_CTRL, 8'h80, 8'h00, "no flag after stop");
		chk("lines idle", 32'h3, {30'h0, scl_w, sda_w});
		// Another party pulls the data line low while the address goes out.
		step(1'b0, 8'h00, 8'hA4, SC_START);
		apb(1'b1, ADDR_DATA, 8'hFE);
		apb(1'b1, ADDR_CTRL, 8'h84);
		jam <= 1'b1;
		wait_ctl(B_FLAG, 1'b1);
		rdc(ADDR_STAT, STAT_CODE_MASK, SC_LOST, "lost");
		apb(1'b1, ADDR_CTRL, 8'hA4);
		// No completion to wait on here: the bus must simply stay untouched.
		repeat (100) @(posedge pclk);
		rdc(ADDR_CTRL, 8'h80, 8'h00, "held off");
		chk("no drive", 32'h0, {31'h0, sda_oe});
		jam <= 1'b0;
		wait_ctl(B_FLAG, 1'b1);
		rdc(ADDR_STAT, STAT_CODE_MASK, SC_START, "start when free");
		apb(1'b1, ADDR_CTRL, 8'h94);
		wait_ctl(B_STO, 1'b0);
		end_sim();
	end
endmodule

// file: testbench/tw_slave_model.sv
// Behavioural slave on the two-wire bus: acks its address, sends read data.
module tw_slave_model #(
	parameter logic [6:0] ADDR      = 7'h2A,
	parameter logic [7:0] NACK_BYTE = 8'hC3
) (
	input  wire logic scl,
	input  wire logic sda,
	output logic      sda_oe
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [3:0] cnt;
	logic [7:0] sh;
	logic [7:0] tx;
	logic       first;
	logic       addr_ok;
	logic       rd;
	logic       mack;

	initial begin
		cnt = 4'hF;
		sh = 8'h00;
		tx = 8'h96;
		first = 1'b0;
		addr_ok = 1'b0;
		rd = 1'b0;
		mack = 1'b0;
		sda_oe = 1'b0;
	end

	// A data edge under a high clock is a start (falling) or a stop (rising).
	always @(sda) begin
		if (scl === 1'b1) begin
			cnt = 4'hF;
			first = !sda;
			sda_oe = 1'b0;
			if (sda)
				addr_ok = 1'b0;
		end
	end

	// Bits are taken while the clock is high; the ack slot records the master.
	always @(posedge scl) begin
		if (cnt < 4'h8)
			sh = {sh[6:0], sda};
		else if (cnt == 4'h8)
			mack = !sda;
	end

	// Changes only after the clock falls, so data never moves under a high clock.
	always @(negedge scl) begin
		if (cnt == 4'hF) begin
			cnt = 4'h0;
		end else if (cnt == 4'h7) begin
			cnt = 4'h8;
			if (first) begin
				addr_ok = (sh[7:1] == ADDR);
				rd = sh[0];
			end else if (rd) begin
				tx = tx + 8'h11;
			end
			sda_oe = addr_ok && (first || (!rd && sh != NACK_BYTE));
			first = 1'b0;
		end else if (cnt == 4'h8) begin
			cnt = 4'h0;
			sda_oe = addr_ok && rd && mack && !tx[7];
		end else begin
			cnt = cnt + 4'h1;
			sda_oe = !first && addr_ok && rd && mack && !tx[4'h7 - cnt];
		end
	end
endmodule
